// *** core/osc_trim_cfd_map.vh ***
// Register indices, field positions, reset values and timing counts of the clock monitor
// Function
// [R01] Auto-trim off: software sets fast oscillator trim through the trim register.
// [R02] Crystal reference auto-trim adjusts trim itself and locks the trim register.
// [R03] Leaving auto-trim copies the last automatic trim value into the trim register.
// [R04] Start-of-frame reference auto-trim trims against frame pulses and locks trim.
// [R05] Frame auto-trim uses binary or incremental search per algorithm select bit.
// [R06] Binary search may move frequency by up to half the trim range.
// [R07] Enable bit starts watching the selected source; in sleep only while it runs.
// [R08] No edge on the monitored clock within the window raises a failure condition.
// [R09] Failure sets the flag; an enabled interrupt stays requested until flag clears.
// [R10] Interrupt type one routes to non-maskable request, zero to normal vector.
// [R11] Main clock failure forces clock select to the fuse start-up source.
// [R12] That override also clears the clock output enable.
// [R13] Condition clears on reset, new toggling, or software clearing the flag.
// [R14] Persistent condition with interrupt enabled re-raises it every ten slow ticks.
// [R15] Test bit injects a fault; non-main source sets flag only.
// [R16] Test bit with main clock monitored switches main clock to start-up source.
// [R17] Writing one to the flag clears it; writing zero leaves it.
// [R18] Run-in-standby keeps an oscillator running in every mode but power-down.
// [R19] Main clock runs active/idle, standby on request, stops in power-down after memory.
// [R20] After reset monitoring waits for the start-up timer of the monitored source.
// [R21] Protected writes need the unlock key first, then a write within four accesses.
// [R22] No-edge window is a parameter counted in slow oscillator ticks.
`ifndef OSC_TRIM_CFD_MAP_VH
`define OSC_TRIM_CFD_MAP_VH

// Register indices; byte address is four times the index
`define IDX_MAIN_CTRL_A     6'h00
`define IDX_MAIN_CTRL_B     6'h01
`define IDX_MAIN_CTRL_C     6'h02
`define IDX_IRQ_CTRL        6'h03
`define IDX_IRQ_FLAGS       6'h04
`define IDX_MAIN_STATUS     6'h05
`define IDX_FAST_CTRL       6'h08
`define IDX_TRIM            6'h09
`define IDX_TRIM_STATUS     6'h0A
`define IDX_SLOW_CTRL       6'h18
`define IDX_XSLOW_CTRL      6'h1C
`define IDX_XFAST_CTRL      6'h20
`define IDX_GUARD           6'h3F

// Field positions
`define BIT_MAIN_CLOCK_OUTPUT_ENABLE          7
`define BIT_FAIL_EN         0
`define BIT_FAIL_TEST       1
`define LSB_MON_SRC         2
`define BIT_IRQ_EN          0
`define BIT_IRQ_TYPE        7
`define BIT_FLAG            0
`define BIT_SEARCH_ALGORITHM_SELECT          6
`define BIT_RUN_IN_STANDBY        7

// Encodings
`define AT_OFF              2'h0
`define AT_XTAL             2'h1
`define AT_SOF              2'h2
`define MON_MAIN            2'h0
`define MON_XFAST           2'h1
`define MON_XSLOW           2'h2
`define SLEEP_ACTIVE        2'h0
`define SLEEP_IDLE          2'h1
`define SLEEP_STANDBY       2'h2
`define SLEEP_PDOWN         2'h3

// Reset values
`define RST_REG             8'h00
`define RST_TRIM            7'h40
// Unlock key value is arbitrary
`define UNLOCK_KEY          8'hA5

// Timing counts
`define GUARD_ACCESSES      3'h4
`define REPEAT_TICKS        4'hA
`define FAIL_WINDOW_TICKS   8
`define STARTUP_TICKS       16
`define TRIM_HALF_RANGE     7'h40

`endif

// *** core/osc_trim_cfd.v ***
// Fast oscillator trimming, clock failure monitor and sleep clock requests with APB access
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "osc_trim_cfd_map.vh"

module osc_trim_cfd #(
   parameter TRIM_W = 7,
   parameter CNT_W = 16,
   parameter TARGET_XTAL = 16'd122,
   parameter TARGET_SOF = 16'd4000,
   parameter FAIL_WINDOW = `FAIL_WINDOW_TICKS,
   parameter STARTUP_WAIT = `STARTUP_TICKS
) (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Oscillator events, one-cycle pulses
   input wire fast_osc_tick,
   input wire slow_xtal_tick,
   input wire sof_pulse,
   input wire internal_slow_osc_tick,
   // Monitored clock levels
   input wire mon_main_level,
   input wire mon_xfast_level,
   input wire mon_xslow_level,
   // Start-up source from fuses
   input wire [3:0] fuse_startup_src,
   // Sleep state and requests
   input wire [1:0] sleep_mode,
   input wire periph_req_main,
   input wire [3:0] periph_req_osc,
   input wire nvm_busy,
   // Clock control outputs
   output reg [TRIM_W-1:0] fast_trim,
   output reg [3:0] main_source_select,
   output reg main_clock_output_enable,
   output reg main_clock_run,
   output reg [3:0] osc_run,
   output reg irq_req,
   output reg nmi_req
);

   // Registers
   reg [7:0] ctrl_a_q, ctrl_b_q, ctrl_c_q, irq_ctrl_q, fast_ctrl_q;
   reg [7:0] slow_ctrl_q, xslow_ctrl_q, xfast_ctrl_q;
   reg [TRIM_W-1:0] trim_q, at_trim_q, at_step_q;
   reg flag_q, cond_q, at_sync_q;
   reg [2:0] guard_q;
   reg [3:0] startup_src_q;
   reg strap_taken_q;
   reg [CNT_W-1:0] osc_cnt_q;
   reg [7:0] idle_cnt_q;
   reg [7:0] start_cnt_q;
   reg [3:0] rep_cnt_q;
   reg [2:0] mon_prev_q;
   reg [1:0] at_prev_q;

   // Bus decode
   wire [5:0] idx = paddr[7:2];
   wire access = psel & penable & pready;
   wire wr = access & pwrite;
   wire [7:0] wd = pwdata[7:0];
   wire unlocked = (guard_q != 3'h0);
   wire pwr = wr & unlocked; // [R21]
   wire mapped = (idx == `IDX_MAIN_CTRL_A) | (idx == `IDX_MAIN_CTRL_B) |
      (idx == `IDX_MAIN_CTRL_C) | (idx == `IDX_IRQ_CTRL) | (idx == `IDX_IRQ_FLAGS) |
      (idx == `IDX_MAIN_STATUS) | (idx == `IDX_FAST_CTRL) | (idx == `IDX_TRIM) |
      (idx == `IDX_TRIM_STATUS) | (idx == `IDX_SLOW_CTRL) | (idx == `IDX_XSLOW_CTRL) |
      (idx == `IDX_XFAST_CTRL) | (idx == `IDX_GUARD);

   // Field views
   wire [1:0] at_sel = fast_ctrl_q[1:0];
   wire at_on = (at_sel == `AT_XTAL) | (at_sel == `AT_SOF);
   wire binary = fast_ctrl_q[`BIT_SEARCH_ALGORITHM_SELECT];
   wire [1:0] mon_src = ctrl_c_q[`LSB_MON_SRC+1:`LSB_MON_SRC];
   wire fail_en = ctrl_c_q[`BIT_FAIL_EN];

   // Auto-trim reference and comparison
   wire ref_evt = ((at_sel == `AT_XTAL) & slow_xtal_tick) | ((at_sel == `AT_SOF) & sof_pulse);
   wire [CNT_W-1:0] target = (at_sel == `AT_SOF) ? TARGET_SOF : TARGET_XTAL;
   wire too_fast = (osc_cnt_q > target);
   wire too_slow = (osc_cnt_q < target);
   wire use_binary = binary & (at_sel == `AT_SOF); // [R05]

   // Monitored source activity
   wire [2:0] mon_lvl = {mon_xslow_level, mon_xfast_level, mon_main_level};
   wire [2:0] mon_toggle = mon_lvl ^ mon_prev_q;
   reg sel_toggle, src_running;
   always @* begin
      case (mon_src)
         `MON_MAIN: begin
            sel_toggle = mon_toggle[0];
            src_running = main_clock_run;
         end
         `MON_XFAST: begin
            sel_toggle = mon_toggle[1];
            src_running = osc_run[3];
         end
         `MON_XSLOW: begin
            sel_toggle = mon_toggle[2];
            src_running = osc_run[2];
         end
         default: begin
            sel_toggle = 1'b0;
            src_running = 1'b0;
         end
      endcase
   end

   wire sleeping = (sleep_mode != `SLEEP_ACTIVE);
   wire watching = fail_en & (!sleeping | src_running); // [R07]
   wire armed = watching & (start_cnt_q >= STARTUP_WAIT[7:0]); // [R20]
   wire timeout = armed & internal_slow_osc_tick &
      (idle_cnt_q + 8'h01 >= FAIL_WINDOW[7:0]); // [R08] [R22]
   wire test_hit = pwr & (idx == `IDX_MAIN_CTRL_C) & wd[`BIT_FAIL_TEST] &
      !ctrl_c_q[`BIT_FAIL_TEST]; // [R15]
   wire fail_evt = (timeout & !cond_q) | test_hit;
   // Injected fault is judged by the source written together with the test bit
   wire [1:0] fail_src = test_hit ? wd[`LSB_MON_SRC+1:`LSB_MON_SRC] : mon_src;
   wire main_fail = fail_evt & (fail_src == `MON_MAIN); // [R11] [R16]
   wire repeat_evt = cond_q & irq_ctrl_q[`BIT_IRQ_EN] & internal_slow_osc_tick &
      (rep_cnt_q == `REPEAT_TICKS - 4'h1); // [R14]
   wire flag_clr = wr & (idx == `IDX_IRQ_FLAGS) & wd[`BIT_FLAG]; // [R17]

   // Unlock guard counts accesses after the key
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         guard_q <= 3'h0;
      end else if (wr & (idx == `IDX_GUARD) & (wd == `UNLOCK_KEY)) begin
         guard_q <= `GUARD_ACCESSES; // [R21]
      end else if (access & unlocked) begin
         guard_q <= guard_q - 3'h1;
      end
   end

   // Start-up source strap caught after reset release
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         strap_taken_q <= 1'b0;
         startup_src_q <= 4'h0;
      end else if (!strap_taken_q) begin
         strap_taken_q <= 1'b1;
         startup_src_q <= fuse_startup_src;
      end
   end

   // Control registers
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_a_q <= `RST_REG;
         ctrl_b_q <= `RST_REG;
         ctrl_c_q <= `RST_REG;
         irq_ctrl_q <= `RST_REG;
         fast_ctrl_q <= `RST_REG;
         slow_ctrl_q <= `RST_REG;
         xslow_ctrl_q <= `RST_REG;
         xfast_ctrl_q <= `RST_REG;
      end else begin
         if (main_fail) begin
            ctrl_a_q <= {1'b0, ctrl_a_q[6:4], startup_src_q}; // [R11] [R12]
         end else if (pwr & (idx == `IDX_MAIN_CTRL_A)) begin
            ctrl_a_q <= {wd[7], 3'h0, wd[3:0]};
         end
         if (pwr & (idx == `IDX_MAIN_CTRL_B)) begin
            ctrl_b_q <= {3'h0, wd[4:0]};
         end
         if (pwr & (idx == `IDX_MAIN_CTRL_C)) begin
            ctrl_c_q <= {4'h0, wd[3:0]};
         end
         if (pwr & (idx == `IDX_IRQ_CTRL)) begin
            irq_ctrl_q <= {wd[7], 6'h00, wd[0]};
         end
         if (pwr & (idx == `IDX_FAST_CTRL)) begin
            fast_ctrl_q <= wd;
         end
         if (pwr & (idx == `IDX_SLOW_CTRL)) begin
            slow_ctrl_q <= {wd[7], 7'h00};
         end
         if (pwr & (idx == `IDX_XSLOW_CTRL)) begin
            xslow_ctrl_q <= {wd[7], 1'b0, wd[5:4], 1'b0, wd[2:0]};
         end
         if (pwr & (idx == `IDX_XFAST_CTRL)) begin
            xfast_ctrl_q <= {wd[7], 1'b0, wd[5:0]};
         end
      end
   end

   // Trim register, written by software only while auto-trim is off
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         trim_q <= `RST_TRIM;
      end else if (pwr & (idx == `IDX_FAST_CTRL) & at_on & (wd[1:0] == `AT_OFF)) begin
         trim_q <= at_trim_q; // [R03]
      end else if (wr & (idx == `IDX_TRIM) & !at_on) begin
         trim_q <= wd[TRIM_W-1:0]; // [R01] [R02] [R04]
      end
   end

   // Auto-trim search
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         at_trim_q <= `RST_TRIM;
         at_step_q <= `TRIM_HALF_RANGE;
         osc_cnt_q <= {CNT_W{1'b0}};
         at_sync_q <= 1'b0;
         at_prev_q <= `AT_OFF;
      end else begin
         at_prev_q <= at_sel;
         if (!at_on) begin
            at_trim_q <= trim_q;
            at_step_q <= `TRIM_HALF_RANGE;
            osc_cnt_q <= {CNT_W{1'b0}};
            at_sync_q <= 1'b0;
         end else if (at_prev_q != at_sel) begin
            // Restart from the current trim (binary search from mid-range) so the search has a clean reference period
            at_step_q <= `TRIM_HALF_RANGE;
            osc_cnt_q <= {CNT_W{1'b0}};
            at_sync_q <= 1'b0;
            if (use_binary) begin
               at_trim_q <= `TRIM_HALF_RANGE; // [R06]
            end
         end else if (ref_evt) begin
            osc_cnt_q <= {CNT_W{1'b0}};
            at_sync_q <= 1'b1;
            if (at_sync_q) begin
               if (use_binary) begin
                  // Step halves each period; may swing half the range early on
                  if (too_fast & (at_trim_q >= at_step_q)) begin
                     at_trim_q <= at_trim_q - at_step_q; // [R06]
                  end else if (too_slow & (at_trim_q <= ~at_step_q)) begin
                     at_trim_q <= at_trim_q + at_step_q; // [R06]
                  end
                  if (at_step_q > {{(TRIM_W-1){1'b0}}, 1'b1}) begin
                     at_step_q <= at_step_q >> 1; // [R05]
                  end
               end else begin
                  if (too_fast & (at_trim_q != {TRIM_W{1'b0}})) begin
                     at_trim_q <= at_trim_q - {{(TRIM_W-1){1'b0}}, 1'b1}; // [R05]
                  end else if (too_slow & (at_trim_q != {TRIM_W{1'b1}})) begin
                     at_trim_q <= at_trim_q + {{(TRIM_W-1){1'b0}}, 1'b1}; // [R05]
                  end
               end
            end
         end else if (fast_osc_tick & (osc_cnt_q != {CNT_W{1'b1}})) begin
            osc_cnt_q <= osc_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // Failure detector
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mon_prev_q <= 3'h0;
         idle_cnt_q <= 8'h00;
         start_cnt_q <= 8'h00;
         rep_cnt_q <= 4'h0;
         cond_q <= 1'b0;
         flag_q <= 1'b0;
      end else begin
         mon_prev_q <= mon_lvl;
         if (!watching) begin
            start_cnt_q <= 8'h00;
         end else if (internal_slow_osc_tick & (start_cnt_q < STARTUP_WAIT[7:0])) begin
            start_cnt_q <= start_cnt_q + 8'h01; // [R20]
         end
         if (!armed | sel_toggle) begin
            idle_cnt_q <= 8'h00;
         end else if (internal_slow_osc_tick & !timeout) begin
            idle_cnt_q <= idle_cnt_q + 8'h01; // [R08]
         end
         if (fail_evt) begin
            cond_q <= 1'b1; // [R08] [R15]
         end else if (sel_toggle | flag_clr | !watching) begin
            cond_q <= 1'b0; // [R13]
         end
         if (!cond_q | (rep_cnt_q == `REPEAT_TICKS - 4'h1) & internal_slow_osc_tick) begin
            rep_cnt_q <= 4'h0;
         end else if (internal_slow_osc_tick) begin
            rep_cnt_q <= rep_cnt_q + 4'h1; // [R14]
         end
         // Set wins over a clear in the same cycle
         if (fail_evt | repeat_evt) begin
            flag_q <= 1'b1; // [R09] [R14]
         end else if (flag_clr) begin
            flag_q <= 1'b0; // [R17]
         end
      end
   end

   // Sleep clock requests
   wire not_pdown = (sleep_mode != `SLEEP_PDOWN);
   wire [3:0] run_in_standby = {xfast_ctrl_q[7], xslow_ctrl_q[7], slow_ctrl_q[7], fast_ctrl_q[7]};
   reg [3:0] sel_onehot;
   always @* begin
      case (ctrl_a_q[3:0])
         4'h0: sel_onehot = 4'h1;
         4'h1: sel_onehot = 4'h2;
         4'h2: sel_onehot = 4'h4;
         4'h3: sel_onehot = 4'h8;
         default: sel_onehot = 4'h0;
      endcase
   end
   reg main_run_d;
   always @* begin
      case (sleep_mode)
         `SLEEP_ACTIVE: main_run_d = 1'b1; // [R19]
         `SLEEP_IDLE: main_run_d = 1'b1; // [R19]
         `SLEEP_STANDBY: main_run_d = periph_req_main | (|(run_in_standby & sel_onehot)); // [R19]
         `SLEEP_PDOWN: main_run_d = nvm_busy; // [R19]
         default: main_run_d = 1'b1;
      endcase
   end

   // Registered outputs
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fast_trim <= `RST_TRIM;
         main_source_select <= 4'h0;
         main_clock_output_enable <= 1'b0;
         main_clock_run <= 1'b1;
         osc_run <= 4'h0;
         irq_req <= 1'b0;
         nmi_req <= 1'b0;
      end else begin
         fast_trim <= at_on ? at_trim_q : trim_q; // [R01] [R02] [R04]
         main_source_select <= ctrl_a_q[3:0];
         main_clock_output_enable <= ctrl_a_q[`BIT_MAIN_CLOCK_OUTPUT_ENABLE] & main_clock_run; // [R12]
         main_clock_run <= main_run_d;
         osc_run <= (run_in_standby & {4{not_pdown}}) | periph_req_osc |
            (sel_onehot & {4{main_run_d}}); // [R18]
         irq_req <= flag_q & irq_ctrl_q[`BIT_IRQ_EN] & !irq_ctrl_q[`BIT_IRQ_TYPE]; // [R09] [R10]
         nmi_req <= flag_q & irq_ctrl_q[`BIT_IRQ_EN] & irq_ctrl_q[`BIT_IRQ_TYPE]; // [R09] [R10]
      end
   end

   // Read mux
   reg [7:0] rd_d;
   always @* begin
      case (idx)
         `IDX_MAIN_CTRL_A: rd_d = ctrl_a_q;
         `IDX_MAIN_CTRL_B: rd_d = ctrl_b_q;
         `IDX_MAIN_CTRL_C: rd_d = ctrl_c_q;
         `IDX_IRQ_CTRL: rd_d = irq_ctrl_q;
         `IDX_IRQ_FLAGS: rd_d = {7'h00, flag_q};
         `IDX_MAIN_STATUS: rd_d = {3'h0, osc_run[3], osc_run[2], osc_run[1], osc_run[0], 1'b0};
         `IDX_FAST_CTRL: rd_d = fast_ctrl_q;
         `IDX_TRIM: rd_d = {{(8-TRIM_W){1'b0}}, at_on ? at_trim_q : trim_q};
         `IDX_TRIM_STATUS: rd_d = {6'h00, at_on, at_sync_q};
         `IDX_SLOW_CTRL: rd_d = slow_ctrl_q;
         `IDX_XSLOW_CTRL: rd_d = xslow_ctrl_q;
         `IDX_XFAST_CTRL: rd_d = xfast_ctrl_q;
         `IDX_GUARD: rd_d = {7'h00, unlocked};
         default: rd_d = 8'h00;
      endcase
   end

   // APB answer: one access cycle, ready and data from flops
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (psel & !penable) begin
         pready <= 1'b1;
         pslverr <= !mapped;
         prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_d};
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

endmodule

// *** tb/osc_trim_cfd_props.sv ***
// Port-level assertions for the trim and clock failure monitor
`timescale 1ns/1ps
module osc_trim_cfd_props (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Sleep inputs
   input wire [1:0] sleep_mode,
   input wire periph_req_main,
   input wire nvm_busy,
   // Clock control outputs
   input wire [3:0] main_source_select,
   input wire main_clock_output_enable,
   input wire main_clock_run,
   input wire irq_req,
   input wire nmi_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   wire wr_done = psel & penable & pready & pwrite;
   wire wr_ctrl_a = wr_done & (paddr[7:2] == 6'h00);
   wire any_req = irq_req | nmi_req;

   property p_ready_after_setup;
      psel && !penable |=> pready;
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready");
   property p_ready_single;
      pready |=> !pready;
   endproperty
   a_ready_single: assert property (p_ready_single) else $error("ready too long");
   property p_err_with_ready;
      pslverr |-> pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("stray error");
   property p_upper_zero;
      pready && !pwrite |-> prdata[31:8] == 24'h000000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
   property p_run_awake;
      sleep_mode < 2'h2 |=> main_clock_run;
   endproperty
   a_run_awake: assert property (p_run_awake) else $error("main stopped awake");
   property p_run_standby;
      sleep_mode == 2'h2 && periph_req_main |=> main_clock_run;
   endproperty
   a_run_standby: assert property (p_run_standby) else $error("main not run");
   property p_run_pdown;
      sleep_mode == 2'h3 && !nvm_busy |=> !main_clock_run;
   endproperty
   a_run_pdown: assert property (p_run_pdown) else $error("main run in pdown");
   property p_irq_excl;
      !(irq_req && nmi_req);
   endproperty
   a_irq_excl: assert property (p_irq_excl) else $error("both requests");
   // A source change not caused by a write must be the fall-back
   property p_fallback;
      $changed(main_source_select) && !$past(wr_ctrl_a) && !$past(wr_ctrl_a, 2)
         |-> !main_clock_output_enable;
   endproperty
   a_fallback: assert property (p_fallback) else $error("main_clock_output_enable kept");
   property p_req_hold;
      $fell(any_req) |-> $past(wr_done) || $past(wr_done, 2);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request dropped");
   c_irq: cover property ($rose(irq_req));
   c_nmi: cover property ($rose(nmi_req));
   c_fallback: cover property ($fell(main_clock_output_enable));
endmodule

bind osc_trim_cfd osc_trim_cfd_props u_props (
   .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sleep_mode(sleep_mode), .periph_req_main(periph_req_main), .nvm_busy(nvm_busy),
   .main_source_select(main_source_select), .main_clock_output_enable(main_clock_output_enable),
   .main_clock_run(main_clock_run), .irq_req(irq_req), .nmi_req(nmi_req)
);

// *** tb/tb_top.sv ***
// Register-level testbench of the trim and clock failure monitor
`timescale 1ns/1ps
`include "osc_trim_cfd_map.vh"
module tb_top;
   reg clk = 1'b0;
   reg resetn = 1'b0;
   reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h00000000;
   reg fast_osc_tick = 1'b0, slow_xtal_tick = 1'b0, sof_pulse = 1'b0;
   reg internal_slow_osc_tick = 1'b0, tog_main = 1'b1;
   reg mon_main_level = 1'b0, mon_xfast_level = 1'b0, mon_xslow_level = 1'b0;
   reg [1:0] sleep_mode = 2'h0;
   reg periph_req_main = 1'b0, nvm_busy = 1'b0;
   reg [3:0] periph_req_osc = 4'h0;
   reg [3:0] tick_cnt = 4'h0;
   reg [7:0] rd;
   reg err;
   wire [31:0] prdata;
   wire pready, pslverr, main_clock_output_enable, main_clock_run, irq_req, nmi_req;
   wire [6:0] fast_trim;
   wire [3:0] main_source_select, osc_run;
   integer failures = 0, n_checks = 0;

   osc_trim_cfd #(.TARGET_XTAL(16'd4), .TARGET_SOF(16'd2), .FAIL_WINDOW(2), .STARTUP_WAIT(4)) dut (
      .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fast_osc_tick(fast_osc_tick), .slow_xtal_tick(slow_xtal_tick), .sof_pulse(sof_pulse),
      .internal_slow_osc_tick(internal_slow_osc_tick), .mon_main_level(mon_main_level),
      .mon_xfast_level(mon_xfast_level), .mon_xslow_level(mon_xslow_level),
      .fuse_startup_src(4'h2), .sleep_mode(sleep_mode), .periph_req_main(periph_req_main),
      .periph_req_osc(periph_req_osc), .nvm_busy(nvm_busy), .fast_trim(fast_trim),
      .main_source_select(main_source_select),
      .main_clock_output_enable(main_clock_output_enable), .main_clock_run(main_clock_run),
      .osc_run(osc_run), .irq_req(irq_req), .nmi_req(nmi_req));

   always #20 clk = ~clk;

   // Slow tick every 8 clocks keeps the failure windows short
   always @(posedge clk) begin
      tick_cnt <= tick_cnt + 4'h1;
      fast_osc_tick <= ~fast_osc_tick;
      internal_slow_osc_tick <= (tick_cnt[2:0] == 3'h7);
      slow_xtal_tick <= (tick_cnt == 4'hF);
      sof_pulse <= (tick_cnt == 4'h8);
      mon_xslow_level <= ~mon_xslow_level;
      mon_xfast_level <= ~mon_xfast_level;
      if (tog_main) begin
         mon_main_level <= ~mon_main_level;
      end
   end

   task chk(input string name, input [31:0] seen, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
         end
      end
   endtask

   task apb(input wr, input [5:0] idx, input [7:0] wd);
      integer n;
      begin
         @(posedge clk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= wr;
         paddr <= {idx, 2'b00};
         pwdata <= {24'h000000, wd};
         @(posedge clk);
         penable <= 1'b1;
         n = 0;
         @(posedge clk);
         while (pready !== 1'b1 && n < 16) begin
            @(posedge clk);
            n = n + 1;
         end
         if (n == 16) begin
            failures = failures + 1;
         end
         rd = prdata[7:0];
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task pw(input [5:0] idx, input [7:0] d);
      begin
         apb(1'b1, `IDX_GUARD, `UNLOCK_KEY);
         apb(1'b1, idx, d);
      end
   endtask

   task rdchk(input string name, input [5:0] idx, input [7:0] exp);
      begin
         apb(1'b0, idx, 8'h00);
         chk(name, {24'h000000, rd}, {24'h000000, exp});
      end
   endtask

   task cyc(input integer k);
      repeat (k) @(posedge clk);
   endtask

   task wait_req;
      integer n;
      begin
         n = 0;
         while (irq_req !== 1'b1 && nmi_req !== 1'b1 && n < 400) begin
            @(posedge clk);
            n = n + 1;
         end
      end
   endtask

   task tally_and_finish;
      begin
         $display("checks %0d failures %0d", n_checks, failures);
         if (failures == 0 && n_checks > 0) begin
            $display("TEST PASSED");
         end else begin
            $display("TEST FAILED");
         end
         $finish;
      end
   endtask

   // Sleep table entries: mode, request and memory busy, expected run
   localparam [23:0] SLP = {4'h1, 4'h5, 4'h8, 4'hB, 4'hF, 4'hC};

   initial begin
      integer i;
      reg [3:0] e;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      chk("trim_reset", 32'(fast_trim), 32'h40);
      chk("run_reset", 32'(main_clock_run), 32'h1);
      apb(1'b0, 6'h07, 8'h00);
      chk("unmapped_err", 32'(err), 32'h1);
      apb(1'b1, `IDX_TRIM, 8'h23);
      cyc(2);
      chk("manual_trim", 32'(fast_trim), 32'h23);
      apb(1'b1, `IDX_MAIN_CTRL_A, 8'h83);
      rdchk("guard_refuse", `IDX_MAIN_CTRL_A, 8'h00);
      pw(`IDX_MAIN_CTRL_A, 8'h83);
      rdchk("guard_unlock", `IDX_MAIN_CTRL_A, 8'h83);
      cyc(2);
      chk("main_clock_output_enable_on", 32'(main_clock_output_enable), 32'h1);
      for (i = 0; i < 3; i = i + 1) begin
         pw(`IDX_FAST_CTRL, (i == 0) ? 8'h01 : (i == 1) ? 8'h02 : 8'h42);
         apb(1'b0, `IDX_TRIM_STATUS, 8'h00);
         chk("trim_lock", 32'(rd[1]), 32'h1);
      end
      pw(`IDX_FAST_CTRL, 8'h00);
      apb(1'b1, `IDX_TRIM, 8'h35);
      cyc(2);
      chk("trim_free", 32'(fast_trim), 32'h35);
      pw(`IDX_IRQ_CTRL, 8'h01);
      pw(`IDX_MAIN_CTRL_C, 8'h07);
      wait_req;
      chk("irq_inject", 32'(irq_req), 32'h1);
      chk("src_kept", 32'(main_source_select), 32'h3);
      rdchk("flag_set", `IDX_IRQ_FLAGS, 8'h01);
      pw(`IDX_IRQ_CTRL, 8'h81);
      cyc(2);
      chk("nmi_route", 32'({nmi_req, irq_req}), 32'h2);
      apb(1'b1, `IDX_IRQ_FLAGS, 8'h00);
      rdchk("flag_keep", `IDX_IRQ_FLAGS, 8'h01);
      apb(1'b1, `IDX_IRQ_FLAGS, 8'h01);
      rdchk("flag_clear", `IDX_IRQ_FLAGS, 8'h00);
      pw(`IDX_MAIN_CTRL_C, 8'h00);
      tog_main <= 1'b0;
      pw(`IDX_IRQ_CTRL, 8'h01);
      pw(`IDX_MAIN_CTRL_C, 8'h01);
      cyc(20);
      chk("startup_quiet", 32'(irq_req), 32'h0);
      wait_req;
      chk("irq_fail", 32'(irq_req), 32'h1);
      cyc(2);
      chk("fallback_src", 32'(main_source_select), 32'h2);
      chk("main_clock_output_enable_off", 32'(main_clock_output_enable), 32'h0);
      rdchk("ctrl_a_forced", `IDX_MAIN_CTRL_A, 8'h02);
      tog_main <= 1'b1;
      apb(1'b1, `IDX_IRQ_FLAGS, 8'h01);
      cyc(100);
      rdchk("cond_cleared", `IDX_IRQ_FLAGS, 8'h00);
      pw(`IDX_MAIN_CTRL_C, 8'h00);
      pw(`IDX_MAIN_CTRL_A, 8'h81);
      pw(`IDX_MAIN_CTRL_C, 8'h02);
      rdchk("test_fallback", `IDX_MAIN_CTRL_A, 8'h02);
      rdchk("test_flag", `IDX_IRQ_FLAGS, 8'h01);
      apb(1'b1, `IDX_IRQ_FLAGS, 8'h01);
      for (i = 0; i < 6; i = i + 1) begin
         e = SLP[4 * (5 - i) +: 4];
         sleep_mode <= e[3:2];
         periph_req_main <= e[1];
         nvm_busy <= e[1];
         cyc(3);
         chk("main_run", 32'(main_clock_run), 32'(e[0]));
      end
      pw(`IDX_SLOW_CTRL, 8'h80);
      sleep_mode <= 2'h2;
      cyc(3);
      chk("slow_standby", 32'(osc_run[1]), 32'h1);
      sleep_mode <= 2'h3;
      cyc(3);
      chk("pdown_all_off", 32'(osc_run), 32'h0);
      periph_req_osc <= 4'h8;
      cyc(3);
      chk("pdown_req_osc", 32'(osc_run), 32'h8);
      sleep_mode <= 2'h0;
      cyc(3);
      tally_and_finish;
   end

   initial begin
      #(40 * 20000);
      failures = failures + 1;
      tally_and_finish;
   end
endmodule
